// File: core/strf_top.v
// Purpose: transmit data register with ready flag, defect reproduced
// Assumes: APB slave, zero wait states, one clock pclk at 100 MHz
// Notes: the same-cycle set/clear collision is kept on purpose
`timescale 1ns/10ps
`default_nettype none
`include "strf_defs.vh"
module strf_top (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// event and serial out
	output reg tx_event,
	output reg tx_data
);
	// ****************************************
	// registers
	// ****************************************
	reg [15:0] tx_word_low;
	reg [15:0] tx_word_high;
	reg tx_ready_flag;
	reg stuck;
	reg tx_enable;
	reg [1:0] tx_event_select;
	reg [7:0] bit_period;

	// state machine and next values
	reg [1:0] state;
	reg [1:0] next_state;
	reg [31:0] next_prdata;
	reg next_event;

	// bus qualifiers and decode
	wire setup;
	wire acc;
	wire wr_acc;
	wire rd_setup;
	wire sel_low;
	wire sel_high;
	wire sel_ctrl;
	wire sel_cfg;
	wire hit;
	wire wr_low;

	// shifter hand-over
	wire pending;
	wire move;
	wire collide;
	wire sh_busy;
	wire sh_done;
	wire sh_out;

	// ****************************************
	// address decode
	// ****************************************
	assign setup = psel & ~penable;
	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	assign rd_setup = setup & ~pwrite;
	assign sel_low = (paddr == `STRF_OFF_WORD_LOW);
	assign sel_high = (paddr == `STRF_OFF_WORD_HIGH);
	assign sel_ctrl = (paddr == `STRF_OFF_CTRL2);
	assign sel_cfg = (paddr == `STRF_OFF_CONFIG);
	// unaligned and unlisted addresses miss every select and get pslverr
	assign hit = sel_low | sel_high | sel_ctrl | sel_cfg;
	assign wr_low = wr_acc & sel_low;

	// ****************************************
	// ready flag state machine
	// ****************************************
	// ready: flag set; pending: a word waits; stuck: collision dropped it
	localparam ST_READY = 2'h0;
	localparam ST_PENDING = 2'h1;
	localparam ST_STUCK = 2'h2;

	assign pending = (state == ST_PENDING);

	always @* begin
		next_state = state;
		case (state)
			ST_READY: begin
				// a low write always clears the flag
				if (wr_low) begin
					next_state = ST_PENDING;
				end
			end
			ST_PENDING: begin
				if (collide) begin
					// the defect: clear wins and the new word is lost
					next_state = ST_STUCK;
				end else if (wr_low) begin
					// a write over a waiting word keeps it waiting
					next_state = ST_PENDING;
				end else if (move) begin
					next_state = ST_READY;
				end
			end
			ST_STUCK: begin
				// no way out but a fresh low write, however long that takes
				if (wr_low) begin
					next_state = ST_PENDING;
				end
			end
			default: begin
				next_state = ST_READY;
			end
		endcase
	end

	// state resets to ready: an empty port accepts a word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_READY;
		end else begin
			state <= next_state;
		end
	end

	// flag and stuck bit are registered copies so reads see no glitch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready_flag <= 1'b1;
		end else begin
			tx_ready_flag <= (next_state == ST_READY);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stuck <= 1'b0;
		end else begin
			stuck <= (next_state == ST_STUCK);
		end
	end

	// ****************************************
	// transfer to shifter
	// ****************************************
	// transfer waits for an idle shifter
	assign move = pending & tx_enable & ~sh_busy;
	// flagged collision: set and clear in the same cycle
	assign collide = move & wr_low;

	// the shifter takes the word only while idle, as move demands
	strf_shifter u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.load(move),
		.load_word({tx_word_high, tx_word_low}),
		.bit_period(bit_period),
		.busy(sh_busy),
		.done(sh_done),
		.tx_data(sh_out)
	);

	// ****************************************
	// apb registers
	// ****************************************
	// the upper half of pwdata is ignored; a word is {high, low}
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_word_low <= 16'h0000;
		end else if (wr_acc & sel_low) begin
			tx_word_low <= pwdata[15:0];
		end
	end

	// write the high half first: only the low write arms a transfer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_word_high <= 16'h0000;
		end else if (wr_acc & sel_high) begin
			tx_word_high <= pwdata[15:0];
		end
	end

	// enable and event select share the second control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_enable <= 1'b0;
			tx_event_select <= `STRF_EVSEL_RDY;
		end else if (wr_acc & sel_ctrl) begin
			tx_enable <= pwdata[`STRF_CTRL2_XEN_BIT];
			tx_event_select <=
				pwdata[`STRF_CTRL2_EVSEL_HI:`STRF_CTRL2_EVSEL_LO];
		end
	end

	// extra cycles per serial bit; zero gives one bit per clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_period <= `STRF_CFG_RESET;
		end else if (wr_acc & sel_cfg) begin
			bit_period <= pwdata[7:0];
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	// read data is picked in setup and registered for the access cycle
	always @* begin
		next_prdata = 32'h00000000;
		if (rd_setup) begin
			if (sel_low) begin
				next_prdata = {16'h0000, tx_word_low};
			end else if (sel_high) begin
				next_prdata = {16'h0000, tx_word_high};
			end else if (sel_ctrl) begin
				// writers poll this before each word
				next_prdata[`STRF_CTRL2_XEN_BIT] = tx_enable;
				next_prdata[`STRF_CTRL2_RDY_BIT] = tx_ready_flag;
				next_prdata[`STRF_CTRL2_EVSEL_HI:`STRF_CTRL2_EVSEL_LO] =
					tx_event_select;
				next_prdata[`STRF_CTRL2_BUSY_BIT] = sh_busy;
				next_prdata[`STRF_CTRL2_STUCK_BIT] = stuck;
			end else if (sel_cfg) begin
				next_prdata = {24'h000000, bit_period};
			end
		end
	end

	// ****************************************
	// transmit event
	// ****************************************
	// event lets a flag-blind writer such as dma pace itself
	always @* begin
		next_event = 1'b0;
		if (tx_event_select == `STRF_EVSEL_RDY) begin
			next_event = tx_ready_flag;
		end else if (tx_event_select == `STRF_EVSEL_DONE) begin
			next_event = sh_done;
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	// answer in the setup cycle so access has pready high: no wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup & ~hit;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// the event lags the flag by one cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_event <= 1'b0;
		end else begin
			tx_event <= next_event;
		end
	end

	// retimed so the pin comes straight from a flip-flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data <= 1'b0;
		end else begin
			tx_data <= sh_out;
		end
	end
endmodule
`default_nettype wire

// File: core/strf_defs.vh
// Purpose: shared constants for the transmit-ready flag block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef STRF_DEFS_VH
`define STRF_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define STRF_OFF_WORD_LOW 12'h000
`define STRF_OFF_WORD_HIGH 12'h004
`define STRF_OFF_CTRL2 12'h008
`define STRF_OFF_CONFIG 12'h00C
// ****************************************
// field positions
// ****************************************
`define STRF_CTRL2_RDY_BIT 1
`define STRF_CTRL2_EVSEL_LO 4
`define STRF_CTRL2_EVSEL_HI 5
`define STRF_CTRL2_BUSY_BIT 8
`define STRF_CTRL2_STUCK_BIT 9
`define STRF_CTRL2_XEN_BIT 0
// ****************************************
// values
// ****************************************
`define STRF_EVSEL_RDY 2'h0
`define STRF_EVSEL_DONE 2'h1
`define STRF_EVSEL_OFF 2'h3
`define STRF_CFG_RESET 8'h1F
`define STRF_BITCNT_W 6
`define STRF_WORD_BITS 6'h20
`define STRF_CNT_ONE 6'h01
`define STRF_CNT_ZERO 6'h00
`endif

// File: core/strf_shifter.v
// Purpose: transmit shift register that sends one 32-bit word msb first
// Assumes: one bit per pclk cycle times (config+1) cycles
// Notes: load is taken only while idle
`timescale 1ns/10ps
`default_nettype none
`include "strf_defs.vh"
module strf_shifter (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// load side
	input wire load,
	input wire [31:0] load_word,
	input wire [7:0] bit_period,
	output reg busy,
	output reg done,
	// serial side
	output reg tx_data
);
	reg [31:0] shift;
	reg [`STRF_BITCNT_W-1:0] bits_left;
	reg [7:0] tick;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift <= 32'h00000000;
			bits_left <= `STRF_CNT_ZERO;
			tick <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			tx_data <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (load) begin
					shift <= {load_word[30:0], 1'b0};
					tx_data <= load_word[31];
					bits_left <= `STRF_WORD_BITS;
					tick <= bit_period;
					busy <= 1'b1;
				end
			end else if (tick != 8'h00) begin
				tick <= tick - 8'h01;
			end else if (bits_left == `STRF_CNT_ONE) begin
				bits_left <= `STRF_CNT_ZERO;
				busy <= 1'b0;
				done <= 1'b1;
				tx_data <= 1'b0;
			end else begin
				bits_left <= bits_left - `STRF_CNT_ONE;
				tx_data <= shift[31];
				shift <= {shift[30:0], 1'b0};
				tick <= bit_period;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/strf_writer.sv
// Purpose: apb writer in place of cpu or dma
// Assumes: tasks entered just after a rising edge
// Notes: waits unbounded, the bench timeout cuts hangs
`timescale 1ns/10ps
`default_nettype none
module strf_writer (
	// apb
	input wire logic pclk,
	output logic psel = 0, penable = 0, pwrite = 0,
	output logic [11:0] paddr = 0,
	output logic [31:0] pwdata = 0,
	input wire logic [31:0] prdata,
	input wire logic pready, pslverr
);
logic [31:0] rdata;
logic err;
task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	@(posedge pclk);
	while (pready !== 1) @(posedge pclk);
	rdata = prdata;
	err = pslverr;
	psel <= 0;
	penable <= 0;
	@(posedge pclk);
endtask
endmodule
`default_nettype wire

// File: verification/strf_top_asserts.sv
// Purpose: port checks for strf_top
// Assumes: event select tracked from bus writes
// Notes: the flag is seen only through tx_event
`timescale 1ns/10ps
`default_nettype none
module strf_chk (
	// apb and event
	input wire logic pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready, pslverr, tx_event
);
logic [1:0] sel;
wire su = psel && !penable;
wire wr = psel && penable && pwrite;
always_ff @(posedge pclk or negedge presetn)
	if (!presetn) sel <= 2'h0;
	else if (wr && paddr == 12'h008) sel <= pwdata[5:4];
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
apb_ready_a: assert property (su |=> pready) else $error("no ready");
ready_cause_a: assert property (pready |-> $past(su)) else $error("stray");
ready_pulse_a: assert property (pready |=> !pready) else $error("long");
err_ready_a: assert property (pslverr |-> pready) else $error("lone err");
bad_addr_a: assert property (su && paddr > 12'h00C |=> pslverr)
	else $error("no err");
good_addr_a: assert property (su && paddr < 12'h00D && paddr[1:0] == 2'h0
	|=> !pslverr) else $error("err");
flag_clear_a: assert property (wr && paddr == 12'h000 && sel == 2'h0
	|-> ##2 !tx_event) else $error("flag kept");
event_off_a: assert property (sel == 2'h3 && $past(sel) == 2'h3
	|-> !tx_event) else $error("event on");
cover property (wr && paddr == 12'h000);
cover property (pslverr);
cover property ($rose(tx_event));
endmodule
bind strf_top strf_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .tx_event(tx_event));
`default_nettype wire

// File: verification/strf_top_tb.sv
// Purpose: self-checking bench for strf_top
// Assumes: bit period 0 keeps words short
// Notes: collision found by sweeping the write gap
`timescale 1ns/10ps
`default_nettype none
module strf_top_tb;
logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, ev;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic ser;
logic [31:0] cap = 0;
int ncap = 0;
int errors = 0, cmp_count = 0, cyc = 0;
strf_writer m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
strf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tx_event(ev), .tx_data(ser));
initial forever #5 pclk = ~pclk;
// the first word sent has its msb set, so its first 1 starts capture
always @(posedge pclk)
	if (ncap < 32 && (ncap > 0 || ser === 1)) begin
		cap <= {cap[30:0], ser};
		ncap <= ncap + 1;
	end
always @(posedge pclk) begin
	cyc <= cyc + 1;
	if (cyc == 20000) begin
		errors++;
		final_report;
	end
end
task chk(input string n, input logic [31:0] e, g);
	cmp_count++;
	if (g !== e) begin
		errors++;
		$display("FAIL %s exp %h got %h", n, e, g);
	end
endtask
task final_report;
	$display("errors %0d compares %0d", errors, cmp_count);
	if (errors == 0 && cmp_count > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
// waits for flag set and shifter idle before any hand-over
task idle;
	m.xfer(12'h008, 0, 0);
	for (int i = 0; i < 99 && (m.rdata & 32'h102) !== 32'h2; i++)
		m.xfer(12'h008, 0, 0);
endtask
task s_regs;
	m.xfer(12'h008, 0, 0);
	chk("ctrl2", 32'h2, m.rdata);
	m.xfer(12'h00C, 0, 0);
	chk("period", 32'h1F, m.rdata);
	m.xfer(12'h010, 1, 32'hF);
	chk("err", 1, m.err);
	m.xfer(12'h00C, 1, 0);
	m.xfer(12'h008, 1, 32'h31);
	@(posedge pclk);
	chk("ev off", 0, ev);
	m.xfer(12'h008, 1, 1);
endtask
task s_send;
	m.xfer(12'h004, 1, 32'hA5A5);
	m.xfer(12'h000, 1, 32'h5A5A);
	m.xfer(12'h008, 0, 0);
	chk("moved", 32'h103, m.rdata);
	m.xfer(12'h000, 1, 32'h0F0F);
	m.xfer(12'h008, 0, 0);
	chk("pending", 32'h101, m.rdata);
	chk("ev", 0, ev);
	idle;
	chk("sent", 32'h3, m.rdata);
	chk("serial", 32'hA5A55A5A, cap);
endtask
// event select 1 gives one pulse at the end of each word
task s_done;
	int n;
	n = 0;
	m.xfer(12'h008, 1, 32'h11);
	m.xfer(12'h000, 1, 5);
	repeat (60) begin
		@(posedge pclk);
		n += ev;
	end
	chk("done pulses", 1, n);
endtask
task s_collide;
	logic hit;
	hit = 0;
	for (int k = 0; k < 40 && !hit; k++) begin
		idle;
		m.xfer(12'h000, 1, 1);
		m.xfer(12'h000, 1, 2);
		repeat (k) @(posedge pclk);
		m.xfer(12'h000, 1, 3);
		m.xfer(12'h008, 0, 0);
		hit = m.rdata[9];
	end
	chk("stuck", 32'h301, m.rdata);
	repeat (200) @(posedge pclk);
	m.xfer(12'h008, 0, 0);
	chk("still", 32'h201, m.rdata);
	m.xfer(12'h000, 1, 4);
	idle;
	chk("resume", 32'h3, m.rdata);
endtask
initial begin
	repeat (20) @(posedge pclk);
	presetn <= 1;
	@(posedge pclk);
	s_regs;
	s_send;
	s_collide;
	s_done;
	final_report;
end
endmodule
`default_nettype wire
